// file: verilog/latch_unit_pkg.sv
// Constants, field layouts and helpers shared by the set-reset latch unit
package latch_unit_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus geometry
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 8;

  // Register indices on the plain register port
  localparam logic [3:0] CTRL_A_ADDR = 4'h0;
  localparam logic [3:0] SOURCE_ADDR = 4'h1;
  localparam logic [3:0] STATUS_ADDR = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of latch_control_a
  localparam int unsigned MASTER_POS     = 7;
  localparam int unsigned DIVIDER_LO_POS = 4;
  localparam int unsigned TRUE_OE_POS    = 3;
  localparam int unsigned COMP_OE_POS    = 2;
  localparam int unsigned SW_SET_POS     = 1;
  localparam int unsigned SW_RESET_POS   = 0;

  // Field positions of the status register
  localparam int unsigned LATCH_STATE_POS = 7;
  localparam int unsigned SYNC_TWO_POS    = 1;
  localparam int unsigned SYNC_ONE_POS    = 0;

  // Reset values
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] SOURCE_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET   = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Periodic pulse timing: code 000 divides by 4, each code doubles it
  localparam int unsigned DIV_SEL_WIDTH = 3;
  localparam int unsigned DIV_CNT_WIDTH = 9;
  localparam logic [9:0]  DIV_BASE      = 10'h004;
  localparam int unsigned GAP_WIDTH     = 10;

  typedef struct packed {
    logic       masterEnable;
    logic [2:0] periodicPulseDivider;
    logic       trueOutputEnable;
    logic       complementOutputEnable;
    logic       swPulseSet;
    logic       swPulseReset;
  } latch_control_a_type;

  typedef struct packed {
    logic externalToSet;
    logic periodicToSetEnable;
    logic cmpTwoToSet;
    logic cmpOneToSet;
    logic externalToReset;
    logic periodicToResetEnable;
    logic cmpTwoToReset;
    logic cmpOneToReset;
  } latch_source_select_type;

  // Divisor minus one, used as a counter mask and by checks
  function automatic logic [8:0] divisorMask(input logic [2:0] sel);
    logic [9:0] div;
    div = DIV_BASE << sel;
    return div[8:0] - 9'h001;
  endfunction

endpackage : latch_unit_pkg

// file: verilog/periodic_pulse_gen.sv
// Periodic one-cycle pulse generator with a selectable power-of-two period
`timescale 1ns/100ps
`default_nettype none

module periodic_pulse_gen
  import latch_unit_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] periodicPulseDivider,
  output logic            periodicPulse
);

  logic [8:0] divCount;
  logic [8:0] mask;
  wire        wrapHit;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running count; pulse when the low bits under the mask are all ones
  assign mask    = divisorMask(periodicPulseDivider); // [RULE_09]
  assign wrapHit = (divCount & mask) == mask;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      divCount      <= 9'h000;
      periodicPulse <= 1'b0;
    end else begin
      divCount      <= divCount + 9'h001;
      periodicPulse <= wrapHit; // [RULE_15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper logic for the checks: gap since the last pulse, divider stability
  logic [9:0] gapCount;
  logic [2:0] prevDivider;
  logic       divHeld;
  wire        divChanged;

  assign divChanged = periodicPulseDivider != prevDivider;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      gapCount    <= 10'h000;
      prevDivider <= 3'h0;
      divHeld     <= 1'b0;
    end else begin
      prevDivider <= periodicPulseDivider;
      if (periodicPulse) begin
        gapCount <= 10'h000;
      end else if (gapCount != 10'h3ff) begin
        gapCount <= gapCount + 10'h001;
      end
      if (divChanged) begin
        divHeld <= 1'b0;
      end else if (periodicPulse) begin
        divHeld <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_pulse_one_wide: assert property (periodicPulse |=> !periodicPulse) // [RULE_15]
    else $error("periodic pulse wider than one cycle");

  a_pulse_period_exact: assert property ( // [RULE_09]
    (periodicPulse && divHeld && !divChanged) |-> (gapCount[8:0] == divisorMask(periodicPulseDivider)))
    else $error("periodic pulse spacing differs from the divider");

endmodule // periodic_pulse_gen

`default_nettype wire

// file: verilog/set_reset_latch_unit.sv
// Set-reset latch unit: source routing, reset-dominant latch, pin drivers
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RULE_01: Latch output follows set and reset inputs at once, not on a clock edge.
// RULE_02: All set and reset inputs are active high.
// RULE_03: Reset wins whenever set and reset are both asserted.
// RULE_04: Software set and reset pulse bits clear themselves after one write.
// RULE_05: Comparator one and two outputs route to set or reset, each enabled.
// RULE_06: Each comparator source may be taken raw or timer-synchronised.
// RULE_07: External trigger pin is a set source and a reset source, separately enabled.
// RULE_08: Periodic pulse generator, 3-bit divider, separately enabled onto set and reset.
// RULE_09: Divider code 000 divides by 4, doubling up to 512 at 111.
// RULE_10: Software must not enable one source onto both set and reset.
// RULE_11: True and complement outputs have own enables and may drive together.
// RULE_12: An output reaches its pin only while its direction bit is clear.
// RULE_13: Device reset leaves the latch state undefined.
// RULE_14: Software must set or reset the latch before enabling any output.
// RULE_15: Periodic pulse is one cycle wide, once every N cycles.
// RULE_16: Software pulse bits assert their input one cycle and read zero.
// RULE_17: Master enable cleared disables the latch and both pin outputs.
// RULE_18: Combined set is OR of enabled set sources; same for reset.
module set_reset_latch_unit
  import latch_unit_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWriteData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regReadData,
  input  wire logic       cmpOneOut,
  input  wire logic       cmpOneSyncedOut,
  input  wire logic       cmpTwoOut,
  input  wire logic       cmpTwoSyncedOut,
  input  wire logic       externalTriggerPin,
  input  wire logic       pinDirectionBitTrue,
  input  wire logic       pinDirectionBitComplement,
  output logic            trueOutPin,
  output logic            trueOutDriveN,
  output logic            complementOutPin,
  output logic            complementOutDriveN
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  latch_control_a_type     latchControlA;
  latch_source_select_type latchSourceSelect;
  logic [1:0]              cmpSyncSelect;
  logic                    swSetPulse;
  logic                    swResetPulse;
  logic                    latchState;

  latch_control_a_type     writeCtrl;
  wire                     ctrlWrite;
  wire                     sourceWrite;
  wire                     statusWrite;

  assign writeCtrl   = latch_control_a_type'(regWriteData);
  assign ctrlWrite   = regWrite && (regAddr == CTRL_A_ADDR);
  assign sourceWrite = regWrite && (regAddr == SOURCE_ADDR);
  assign statusWrite = regWrite && (regAddr == STATUS_ADDR);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      latchControlA     <= latch_control_a_type'(CTRL_A_RESET);
      latchSourceSelect <= latch_source_select_type'(SOURCE_RESET);
      cmpSyncSelect     <= SYNC_RESET;
    end else begin
      if (ctrlWrite) begin
        latchControlA              <= writeCtrl;
        // Pulse bits never stay stored, so they always read back as zero
        latchControlA.swPulseSet   <= 1'b0; // [RULE_16]
        latchControlA.swPulseReset <= 1'b0; // [RULE_16]
      end
      if (sourceWrite) begin
        latchSourceSelect <= latch_source_select_type'(regWriteData);
      end
      if (statusWrite) begin
        cmpSyncSelect <= regWriteData[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software pulses: one write gives exactly one cycle of drive

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      swSetPulse   <= 1'b0;
      swResetPulse <= 1'b0;
    end else begin
      swSetPulse   <= ctrlWrite && writeCtrl.swPulseSet;   // [RULE_04]
      swResetPulse <= ctrlWrite && writeCtrl.swPulseReset; // [RULE_04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic pulse source

  logic periodicPulse;

  periodic_pulse_gen u_periodic_pulse_gen (
    .ref_clk              (ref_clk),
    .resetn               (resetn),
    .periodicPulseDivider (latchControlA.periodicPulseDivider), // [RULE_08] [RULE_09] [RULE_15]
    .periodicPulse        (periodicPulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and combination

  wire cmpOneSource;
  wire cmpTwoSource;
  wire anySetSource;
  wire anyResetSource;
  wire combinedSet;
  wire combinedReset;
  wire latchQ;

  // Synchronised forms come from the comparator block already timed to the
  // timer clock; this block only chooses between the two forms
  assign cmpOneSource = cmpSyncSelect[SYNC_ONE_POS] ? cmpOneSyncedOut : cmpOneOut; // [RULE_06]
  assign cmpTwoSource = cmpSyncSelect[SYNC_TWO_POS] ? cmpTwoSyncedOut : cmpTwoOut; // [RULE_06]

  // Every source is taken high-true; no inversion anywhere on the path
  assign anySetSource = swSetPulse // [RULE_02] [RULE_18]
    | (latchSourceSelect.cmpOneToSet && cmpOneSource) // [RULE_05]
    | (latchSourceSelect.cmpTwoToSet && cmpTwoSource) // [RULE_05]
    | (latchSourceSelect.externalToSet && externalTriggerPin) // [RULE_07]
    | (latchSourceSelect.periodicToSetEnable && periodicPulse); // [RULE_08]

  assign anyResetSource = swResetPulse // [RULE_02] [RULE_18]
    | (latchSourceSelect.cmpOneToReset && cmpOneSource) // [RULE_05]
    | (latchSourceSelect.cmpTwoToReset && cmpTwoSource) // [RULE_05]
    | (latchSourceSelect.externalToReset && externalTriggerPin) // [RULE_07]
    | (latchSourceSelect.periodicToResetEnable && periodicPulse); // [RULE_08]

  // A disabled latch ignores all of its sources and holds its state
  assign combinedSet   = latchControlA.masterEnable && anySetSource;   // [RULE_17]
  assign combinedReset = latchControlA.masterEnable && anyResetSource; // [RULE_17]

  ////////////////////////////////////////////////////////////////////////////
  // The latch itself
  // The output is a combinational function of the inputs, so it moves in the
  // same cycle as a source; the flop only remembers it between events. This
  // keeps the design free of a real latch at the cost of one mux level.

  assign latchQ = combinedReset ? 1'b0 : // [RULE_03]
                  combinedSet   ? 1'b1 : // [RULE_01]
                  latchState;

  // Deliberately outside the reset branch: the state is unknown after reset
  always_ff @(posedge ref_clk) begin
    latchState <= latchQ; // [RULE_13]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers: drive enables are active low

  wire trueDrive;
  wire complementDrive;

  assign trueDrive = latchControlA.masterEnable // [RULE_17]
    && latchControlA.trueOutputEnable // [RULE_11]
    && !pinDirectionBitTrue; // [RULE_12]
  assign complementDrive = latchControlA.masterEnable // [RULE_17]
    && latchControlA.complementOutputEnable // [RULE_11]
    && !pinDirectionBitComplement; // [RULE_12]

  // Pin data is parked low when not driven so an unknown state never leaks
  assign trueOutPin          = trueDrive && latchQ;
  assign trueOutDriveN       = !trueDrive;
  assign complementOutPin    = complementDrive && !latchQ;
  assign complementOutDriveN = !complementDrive;

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data stand only in the cycle after the read strobe

  logic [7:0] readMux;
  logic [7:0] statusWord;

  always_comb begin
    statusWord                  = 8'h00;
    statusWord[LATCH_STATE_POS] = latchQ;
    statusWord[SYNC_TWO_POS]    = cmpSyncSelect[1];
    statusWord[SYNC_ONE_POS]    = cmpSyncSelect[0];
  end

  always_comb begin
    case (regAddr)
      CTRL_A_ADDR: readMux = latchControlA; // [RULE_16]
      SOURCE_ADDR: readMux = latchSourceSelect;
      STATUS_ADDR: readMux = statusWord;
      default:     readMux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= regRead ? readMux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence swSetWrite;
    ctrlWrite && writeCtrl.swPulseSet && writeCtrl.masterEnable;
  endsequence

  sequence swResetWrite;
    ctrlWrite && writeCtrl.swPulseReset && writeCtrl.masterEnable;
  endsequence

  // A retrigger in the next cycle legally stretches the pulse, so it is left out
  sequence swSetAlone;
    swSetWrite ##1 !(ctrlWrite && writeCtrl.swPulseSet);
  endsequence

  sequence swResetAlone;
    swResetWrite ##1 !(ctrlWrite && writeCtrl.swPulseReset);
  endsequence

  sequence singlePulse(sig);
    sig ##1 !sig;
  endsequence

  a_reset_dominates: assert property (combinedReset |-> !latchQ) // [RULE_03]
    else $error("latch not reset while reset input active");

  a_set_immediate: assert property ((combinedSet && !combinedReset) |-> latchQ) // [RULE_01]
    else $error("latch did not set in the cycle of its set input");

  a_sw_set_pulse: assert property (swSetAlone |-> singlePulse(swSetPulse)) // [RULE_04]
    else $error("software set pulse not exactly one cycle");

  a_sw_set_effect: assert property ( // [RULE_16]
    swSetWrite |=> (latchQ || combinedReset) ##1 (latchQ || anyResetSource || $past(combinedReset)))
    else $error("software set pulse did not set the latch");

  a_sw_reset_effect: assert property (swResetAlone |-> singlePulse(swResetPulse) and !latchQ) // [RULE_04]
    else $error("software reset pulse did not reset the latch");

  a_pulse_bits_zero: assert property (regRead && regAddr == CTRL_A_ADDR |=> regReadData[1:0] == 2'h0) // [RULE_16]
    else $error("software pulse bits read back nonzero");

  a_cmp_one_route: assert property ( // [RULE_05]
    (latchControlA.masterEnable && latchSourceSelect.cmpOneToSet && cmpOneSource && !anyResetSource) |-> latchQ)
    else $error("comparator one did not set the latch");

  a_external_route: assert property ( // [RULE_07]
    (latchControlA.masterEnable && latchSourceSelect.externalToReset && externalTriggerPin) |-> !latchQ)
    else $error("external trigger did not reset the latch");

  a_disabled_quiet: assert property ( // [RULE_17]
    !latchControlA.masterEnable |-> (trueOutDriveN && complementOutDriveN && !combinedSet && !combinedReset))
    else $error("disabled latch still drives or responds");

  a_pin_gating: assert property ( // [RULE_12]
    !trueOutDriveN |-> (!pinDirectionBitTrue && latchControlA.trueOutputEnable && trueOutPin == latchQ))
    else $error("true output driven without its enables");

  a_outputs_together: assert property ( // [RULE_11]
    (!trueOutDriveN && !complementOutDriveN) |-> (trueOutPin != complementOutPin))
    else $error("true and complement pins not complementary");

  // State is unknown until the first event, so the hold checks start from one
  sequence latchSetEvent;
    combinedSet && !combinedReset;
  endsequence

  sequence latchResetEvent;
    combinedReset;
  endsequence

  sequence periodicSetEvent;
    latchControlA.masterEnable && latchSourceSelect.periodicToSetEnable && periodicPulse;
  endsequence

  sequence periodicResetEvent;
    latchControlA.masterEnable && latchSourceSelect.periodicToResetEnable && periodicPulse;
  endsequence

  a_set_remembered: assert property (latchSetEvent ##1 !combinedReset |-> latchQ) // [RULE_01]
    else $error("latch lost its set state");

  a_reset_remembered: assert property (latchResetEvent ##1 !combinedSet |-> !latchQ) // [RULE_01]
    else $error("latch lost its reset state");

  a_periodic_set: assert property (periodicSetEvent |-> (latchQ || anyResetSource)) // [RULE_08]
    else $error("periodic pulse did not set the latch");

  a_periodic_reset: assert property (periodicResetEvent |-> !latchQ) // [RULE_08]
    else $error("periodic pulse did not reset the latch");

  a_cmp_one_reset: assert property ( // [RULE_05]
    (latchControlA.masterEnable && latchSourceSelect.cmpOneToReset && cmpOneSource) |-> !latchQ)
    else $error("comparator one did not reset the latch");

  a_cmp_two_set: assert property ( // [RULE_05]
    (latchControlA.masterEnable && latchSourceSelect.cmpTwoToSet && cmpTwoSource) |-> (latchQ || anyResetSource))
    else $error("comparator two did not set the latch");

  a_cmp_two_reset: assert property ( // [RULE_05]
    (latchControlA.masterEnable && latchSourceSelect.cmpTwoToReset && cmpTwoSource) |-> !latchQ)
    else $error("comparator two did not reset the latch");

  a_external_set: assert property ( // [RULE_07]
    (latchControlA.masterEnable && latchSourceSelect.externalToSet && externalTriggerPin)
      |-> (latchQ || anyResetSource))
    else $error("external trigger did not set the latch");

  // Once selected, the synced form is obeyed whatever the raw form does
  a_synced_one_set: assert property ( // [RULE_06]
    (latchControlA.masterEnable && latchSourceSelect.cmpOneToSet && cmpSyncSelect[SYNC_ONE_POS]
      && cmpOneSyncedOut) |-> (latchQ || anyResetSource))
    else $error("synced comparator one did not set the latch");

  a_synced_two_reset: assert property ( // [RULE_06]
    (latchControlA.masterEnable && latchSourceSelect.cmpTwoToReset && cmpSyncSelect[SYNC_TWO_POS]
      && cmpTwoSyncedOut) |-> !latchQ)
    else $error("synced comparator two did not reset the latch");

  // Complement pin has its own enable and direction bit
  a_comp_gating: assert property ( // [RULE_12]
    !complementOutDriveN |-> (!pinDirectionBitComplement && latchControlA.complementOutputEnable
      && complementOutPin == !latchQ))
    else $error("complement output driven without its enables");

  a_undriven_parked: assert property ( // [RULE_12]
    (trueOutDriveN |-> !trueOutPin) and (complementOutDriveN |-> !complementOutPin))
    else $error("undriven pin not parked low");

  // Read data stand one cycle only; an idle bus reads zero
  a_read_idle: assert property (!regRead |=> regReadData == 8'h00)
    else $error("read data outside the answer cycle");

endmodule // set_reset_latch_unit

`default_nettype wire

// file: verification/tb.sv
// Self-checking testbench for the set-reset latch unit
`timescale 1ns/100ps
`default_nettype none

module tb;
  import latch_unit_pkg::*;

  localparam logic [7:0] SET_MASK [3] = '{8'h10, 8'h20, 8'h80};
  localparam logic [7:0] RST_MASK [3] = '{8'h01, 8'h02, 8'h08};
  localparam int         CYCLE_LIMIT  = 20000;

  logic       ref_clk      = 1'b0;
  logic       resetn       = 1'b0;
  logic [3:0] regAddr      = 4'h0;
  logic [7:0] regWriteData = 8'h00;
  logic       regWrite     = 1'b0;
  logic       regRead      = 1'b0;
  logic [7:0] regReadData;
  logic [2:0] rawSrc       = 3'h0;
  logic [1:0] syncSrc      = 2'h0;
  logic [1:0] dirBit       = 2'h0;
  logic       trueOutPin;
  logic       trueOutDriveN;
  logic       complementOutPin;
  logic       complementOutDriveN;
  logic [7:0] rdData;
  int         gap;
  int         failCount    = 0;
  int         numChecks    = 0;
  int         cycles       = 0;

  always #25 ref_clk = ~ref_clk;

  set_reset_latch_unit set_reset_latch_unit_i (
    .ref_clk                   (ref_clk),
    .resetn                    (resetn),
    .regAddr                   (regAddr),
    .regWriteData              (regWriteData),
    .regWrite                  (regWrite),
    .regRead                   (regRead),
    .regReadData               (regReadData),
    .cmpOneOut                 (rawSrc[0]),
    .cmpOneSyncedOut           (syncSrc[0]),
    .cmpTwoOut                 (rawSrc[1]),
    .cmpTwoSyncedOut           (syncSrc[1]),
    .externalTriggerPin        (rawSrc[2]),
    .pinDirectionBitTrue       (dirBit[0]),
    .pinDirectionBitComplement (dirBit[1]),
    .trueOutPin                (trueOutPin),
    .trueOutDriveN             (trueOutDriveN),
    .complementOutPin          (complementOutPin),
    .complementOutDriveN       (complementOutDriveN)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Order: true pin, true drive (low drives), complement pin, complement drive
  task automatic pins(input logic [3:0] exp, input string what);
    chk({12'h000, trueOutPin, trueOutDriveN, complementOutPin, complementOutDriveN}, {12'h000, exp}, what);
  endtask

  // Returns one cycle into the write's effect, so a pulse cycle is visible
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrite     <= 1'b1;
    regAddr      <= a;
    regWriteData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    d = regReadData;
  endtask

  // Cycles until the true pin is next seen low, bounded so a dead divider cannot hang
  task automatic waitLow(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (trueOutPin !== 1'b0 && n < 1100);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      failCount++;
      $display("Error at %0t: run did not complete", $time);
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    pins(4'b0101, "pins after reset");
    rd(CTRL_A_ADDR, rdData);
    chk(rdData, CTRL_A_RESET, "control reset value");
    rd(SOURCE_ADDR, rdData);
    chk(rdData, SOURCE_RESET, "source reset value");
    rd(STATUS_ADDR, rdData);
    chk(rdData & 8'h7f, 8'h00, "status reset value");
    $display("test reset done");

    // Latch is made known before any output is enabled
    wr(CTRL_A_ADDR, 8'h82);
    pins(4'b0101, "outputs disabled");
    rd(STATUS_ADDR, rdData);
    chk(rdData, 8'h80, "software set");
    wr(CTRL_A_ADDR, 8'h8c);
    pins(4'b1000, "both outputs driven");
    wr(CTRL_A_ADDR, 8'h8d);
    pins(4'b0010, "software reset");
    wr(CTRL_A_ADDR, 8'h8e);
    pins(4'b1000, "software set again");
    wr(CTRL_A_ADDR, 8'h8f);
    pins(4'b0010, "reset dominates");
    rd(CTRL_A_ADDR, rdData);
    chk(rdData, 8'h8c, "pulse bits read zero");
    @(posedge ref_clk);
    dirBit <= 2'b01;
    #1;
    pins(4'b0110, "direction bit blocks");
    @(posedge ref_clk);
    dirBit <= 2'b00;
    wr(CTRL_A_ADDR, 8'h0c);
    pins(4'b0101, "master off");
    wr(CTRL_A_ADDR, 8'h0e);
    wr(CTRL_A_ADDR, 8'h8c);
    pins(4'b0010, "set ignored while off");
    $display("test software pulses done");

    // Each hardware source sets, then resets against another set source
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_A_ADDR, 8'h8d);
      wr(SOURCE_ADDR, SET_MASK[i]);
      @(posedge ref_clk);
      rawSrc[i] <= 1'b1;
      #1;
      pins(4'b1000, "source sets at once");
      @(posedge ref_clk);
      rawSrc[i] <= 1'b0;
      #1;
      pins(4'b1000, "latch holds set");
      wr(SOURCE_ADDR, RST_MASK[i] | SET_MASK[(i + 1) % 3]);
      @(posedge ref_clk);
      rawSrc[i]           <= 1'b1;
      rawSrc[(i + 1) % 3] <= 1'b1;
      #1;
      pins(4'b0010, "source reset wins");
      @(posedge ref_clk);
      rawSrc <= 3'h0;
    end
    $display("test hardware sources done");

    // Synced comparator form replaces the raw one
    wr(STATUS_ADDR, 8'h03);
    wr(CTRL_A_ADDR, 8'h8d);
    wr(SOURCE_ADDR, 8'h10);
    @(posedge ref_clk);
    rawSrc[0] <= 1'b1;
    #1;
    pins(4'b0010, "raw ignored when synced");
    @(posedge ref_clk);
    syncSrc[0] <= 1'b1;
    #1;
    pins(4'b1000, "synced comparator one");
    @(posedge ref_clk);
    rawSrc  <= 3'h0;
    syncSrc <= 2'h0;
    wr(SOURCE_ADDR, 8'h02);
    @(posedge ref_clk);
    syncSrc[1] <= 1'b1;
    #1;
    pins(4'b0010, "synced comparator two");
    @(posedge ref_clk);
    syncSrc <= 2'h0;
    rd(STATUS_ADDR, rdData);
    chk(rdData, 8'h03, "status readback");
    wr(STATUS_ADDR, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, rdData);
    chk(rdData, 8'h00, "unmapped read");
    rd(CTRL_A_ADDR, rdData);
    chk(rdData, 8'h8c, "unmapped write ignored");
    $display("test synced sources done");

    // External pin holds set; each periodic reset pulse shows as one low cycle
    wr(SOURCE_ADDR, 8'h84);
    @(posedge ref_clk);
    rawSrc[2] <= 1'b1;
    for (int code = 0; code < 8; code++) begin
      wr(CTRL_A_ADDR, {1'b1, 3'(code), 4'h8});
      waitLow(gap);
      waitLow(gap);
      waitLow(gap);
      chk(16'(gap), 16'(4 << code), "periodic gap");
      @(posedge ref_clk);
      #1;
      chk({15'h0000, trueOutPin}, 16'h0001, "pulse one cycle wide");
    end
    @(posedge ref_clk);
    rawSrc <= 3'h0;
    wr(CTRL_A_ADDR, 8'h8d);
    wr(SOURCE_ADDR, 8'h40);
    repeat (5) @(posedge ref_clk);
    #1;
    pins(4'b1000, "periodic source sets");
    $display("test periodic pulse done");

    // A mid-run reset clears the registers but must leave the latch where it was
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    pins(4'b0101, "pins after mid-run reset");
    rd(STATUS_ADDR, rdData);
    chk(rdData, 8'h80, "latch kept over reset");
    rd(CTRL_A_ADDR, rdData);
    chk(rdData, CTRL_A_RESET, "control cleared by reset");
    $display("test mid-run reset done");

    finish_test();
  end

endmodule // tb

`default_nettype wire
